// ---- mfrp_profiler.sv ----
// Motor frequency ramp profiler: settings, start sequence and ramp
`timescale 1ns/1ps
`default_nettype none
`include "mfrp_defs.svh"

module mfrp_profiler #(
	parameter int FINE_CYC = `MFRP_FINE_MS * `MFRP_CLK_KHZ,
	parameter int COARSE_CYC = `MFRP_COARSE_MS * `MFRP_CLK_KHZ,
	parameter int MIN_CYC = `MFRP_MIN_MS * `MFRP_CLK_KHZ,
	parameter int LIM_CYC = `MFRP_LIM_MS * `MFRP_CLK_KHZ
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire mfrp_pkg::mfrp_bus_t bus,
	output logic [15:0] rd_data_reg,
	input wire logic fwd_start_pin,
	input wire logic rev_start_pin,
	input wire logic second_set_select,
	output mfrp_pkg::mfrp_cmd_t motor_cmd_reg
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (FINE_CYC < 1 || COARSE_CYC < FINE_CYC || LIM_CYC < 1 ||
		MIN_CYC <= LIM_CYC)
	begin : g_bad_params
		$error("mfrp_profiler: unusable timing parameters");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_meta_reg;
	logic [2:0] pin_sync_reg;
	logic fwd_on;
	logic rev_on;
	logic sel_on;

	// Two stages; only the second stage is read
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
		end
		else
		begin
			pin_meta_reg <= {second_set_select, rev_start_pin, fwd_start_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign fwd_on = pin_sync_reg[0];
	assign rev_on = pin_sync_reg[1];
	assign sel_on = pin_sync_reg[2];

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	logic [15:0] cfg_reg [`MFRP_NUM_CFG];

	// Writes beyond the setting words are dropped
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < `MFRP_NUM_CFG; i++)
				cfg_reg[i] <= mfrp_pkg::mfrp_rst_val(4'(i));
		end
		else if (bus.wr && bus.addr < `MFRP_NUM_CFG_A)
		begin
			cfg_reg[bus.addr] <= bus.wdata;
		end
	end

	logic [1:0] shape;
	logic incr_fine;
	logic [15:0] set_f;
	logic [15:0] sw_f;
	logic [15:0] start_f;
	logic [15:0] base_f;
	logic [15:0] min_f;
	logic [15:0] ref_f;
	logic [15:0] hold_raw;

	assign shape = cfg_reg[`MFRP_A_CTRL][`MFRP_CTRL_SHAPE];
	assign incr_fine = cfg_reg[`MFRP_A_CTRL][`MFRP_CTRL_INCR];
	assign set_f = cfg_reg[`MFRP_A_SET_FREQ];
	assign sw_f = cfg_reg[`MFRP_A_SW_FREQ];
	assign base_f = cfg_reg[`MFRP_A_BASE];
	assign min_f = cfg_reg[`MFRP_A_MIN_FREQ];
	assign ref_f = cfg_reg[`MFRP_A_REF_FREQ];
	assign hold_raw = cfg_reg[`MFRP_A_HOLD];
	// Starting frequency tops out at 60Hz
	assign start_f = (cfg_reg[`MFRP_A_START_FREQ] > `MFRP_START_MAX) ?
		`MFRP_START_MAX : cfg_reg[`MFRP_A_START_FREQ];

	// ----------------------------------------------------------------
	// Run state
	// ----------------------------------------------------------------
	mfrp_pkg::mfrp_state_t st_reg;
	logic [15:0] out_reg;
	logic dir_reg;
	logic [63:0] acc_reg;
	logic [15:0] origin_reg;
	logic [15:0] goal_last_reg;
	logic [31:0] hold_cnt_reg;

	logic start_on;
	logic [15:0] cmd_f;
	logic start_ok;
	logic rev_ok;
	logic launch;
	logic hold_en;
	logic hold_done;
	logic [15:0] goal;

	// Both lines on is treated as a stop
	assign start_on = fwd_on ^ rev_on;

	// Low starting frequency lets the minimum act as preset command
	assign cmd_f = (start_f <= min_f && set_f < min_f) ? min_f : set_f;

	// Start only once command reaches the starting frequency
	assign start_ok = start_on && cmd_f >= start_f && cmd_f != 16'h0;

	// Reversal restarts at starting frequency, hold is skipped
	assign rev_ok = st_reg == mfrp_pkg::MFRP_ST_RUN && out_reg == 16'h0 &&
		start_on && rev_on != dir_reg && start_ok;

	assign launch = (st_reg == mfrp_pkg::MFRP_ST_IDLE && start_ok) || rev_ok;
	assign hold_en = hold_raw != `MFRP_NOFUNC;
	assign hold_done = 64'(hold_cnt_reg) + 64'h1 >=
		64'(hold_raw) * 64'(COARSE_CYC);

	// Target is command while run direction matches, else zero
	assign goal = (st_reg == mfrp_pkg::MFRP_ST_RUN && start_on &&
		rev_on == dir_reg) ? cmd_f : 16'h0;

	// Sequencer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_reg <= mfrp_pkg::MFRP_ST_IDLE;
		end
		else
		begin
			case (st_reg)
				mfrp_pkg::MFRP_ST_IDLE:
					if (start_ok)
						st_reg <= hold_en ? mfrp_pkg::MFRP_ST_HOLD
							: mfrp_pkg::MFRP_ST_RUN;
				mfrp_pkg::MFRP_ST_HOLD:
					// Losing start ends the hold early
					if (!start_on || rev_on != dir_reg || hold_done)
						st_reg <= mfrp_pkg::MFRP_ST_RUN;
				mfrp_pkg::MFRP_ST_RUN:
					if (out_reg == 16'h0 && goal == 16'h0 && !rev_ok)
						st_reg <= mfrp_pkg::MFRP_ST_IDLE;
				default:
					st_reg <= mfrp_pkg::MFRP_ST_IDLE;
			endcase
		end
	end

	// Hold timer counts clock cycles in hold only
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hold_cnt_reg <= 32'h0;
		else if (st_reg == mfrp_pkg::MFRP_ST_HOLD)
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
		else
			hold_cnt_reg <= 32'h0;
	end

	// Direction latched at each launch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			dir_reg <= 1'b0;
		else if (launch)
			dir_reg <= rev_on;
	end

	// ----------------------------------------------------------------
	// Time set selection
	// ----------------------------------------------------------------
	logic sec_on;
	logic going_up;
	logic [15:0] raw_t;
	logic [63:0] t_cyc;

	// Select line wins at once; code 9999 turns switching off
	assign sec_on = sel_on || (sw_f != `MFRP_NOFUNC && out_reg >= sw_f);
	assign going_up = out_reg < goal;

	always_comb
	begin
		if (!sec_on)
			raw_t = going_up ? cfg_reg[`MFRP_A_ACC1] : cfg_reg[`MFRP_A_DEC1];
		else if (going_up || cfg_reg[`MFRP_A_DEC2] == `MFRP_NOFUNC)
			raw_t = cfg_reg[`MFRP_A_ACC2];
		else
			raw_t = cfg_reg[`MFRP_A_DEC2];
		// Increment select scales the setting to cycles
		t_cyc = 64'(raw_t) * 64'(incr_fine ? FINE_CYC : COARSE_CYC);
		// Very short times are stretched to the minimum ramp
		if (t_cyc <= 64'(LIM_CYC))
			t_cyc = 64'(MIN_CYC);
	end

	// ----------------------------------------------------------------
	// Slope per shape
	// ----------------------------------------------------------------
	logic [63:0] num;
	logic [63:0] den;
	logic [15:0] span;
	logic [15:0] d_from;
	logic [15:0] d_to;
	logic edge_q;

	// Curve B quarters from the segment ends
	assign span = (goal > origin_reg) ? goal - origin_reg : origin_reg - goal;
	assign d_from = (out_reg > origin_reg) ? out_reg - origin_reg
		: origin_reg - out_reg;
	assign d_to = (out_reg > goal) ? out_reg - goal : goal - out_reg;
	assign edge_q = d_from < (span >> 2) || d_to < (span >> 2);

	// Rate is num/den steps of 0.1Hz per cycle
	always_comb
	begin
		num = 64'(ref_f);
		den = t_cyc;
		case (shape)
			mfrp_pkg::MFRP_SHAPE_A:
			begin
				if (base_f == 16'h0)
				begin
					num = 64'(ref_f);
				end
				else if (out_reg < base_f)
				begin
					num = 64'(base_f);
				end
				else
				begin
					// Slope falls as 1/f above the inflection
					num = `MFRP_SA_NUM * 64'(base_f) * 64'(base_f);
					den = `MFRP_SA_DEN * t_cyc * 64'(out_reg);
				end
			end
			mfrp_pkg::MFRP_SHAPE_B:
			begin
				// Slow outer quarters, fast middle: coarse S
				num = edge_q ? 64'(ref_f >> 1)
					: 64'(ref_f) + 64'(ref_f >> 1);
			end
			default:
			begin
				num = 64'(ref_f);
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Ramp integrator
	// ----------------------------------------------------------------
	logic [63:0] acc_sum;
	assign acc_sum = acc_reg + num;

	// Remember where each new segment starts
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			origin_reg <= 16'h0;
			goal_last_reg <= 16'h0;
		end
		else if (goal != goal_last_reg)
		begin
			origin_reg <= out_reg;
			goal_last_reg <= goal;
		end
	end

	// One step of 0.1Hz at most per cycle, so no overshoot
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_reg <= 16'h0;
			acc_reg <= 64'h0;
		end
		else if (launch)
		begin
			out_reg <= start_f;
			acc_reg <= 64'h0;
		end
		else if (st_reg != mfrp_pkg::MFRP_ST_RUN || out_reg == goal)
		begin
			acc_reg <= 64'h0;
		end
		else if (acc_sum >= den)
		begin
			out_reg <= going_up ? out_reg + 16'h1 : out_reg - 16'h1;
			acc_reg <= acc_sum - den;
		end
		else
		begin
			acc_reg <= acc_sum;
		end
	end

	// ----------------------------------------------------------------
	// Outputs and readback
	// ----------------------------------------------------------------
	logic [15:0] status;
	assign status = {11'h0, sec_on, dir_reg, st_reg};

	// Command to the power stage
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			motor_cmd_reg <= '0;
		else
		begin
			motor_cmd_reg.freq <= out_reg;
			motor_cmd_reg.reverse <= dir_reg;
			motor_cmd_reg.running <= st_reg != mfrp_pkg::MFRP_ST_IDLE;
			motor_cmd_reg.second_set <= sec_on;
		end
	end

	// Read data stands only in the cycle after each read strobe, zero otherwise
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_data_reg <= 16'h0;
		else if (!bus.rd)
			rd_data_reg <= 16'h0;
		else if (bus.addr < `MFRP_NUM_CFG_A)
			rd_data_reg <= cfg_reg[bus.addr];
		else if (bus.addr == `MFRP_A_OUT)
			rd_data_reg <= out_reg;
		else if (bus.addr == `MFRP_A_STAT)
			rd_data_reg <= status;
		else
			rd_data_reg <= 16'h0;
	end

endmodule : mfrp_profiler

`default_nettype wire

// ---- mfrp_defs.svh ----
// Constants of the motor frequency ramp profiler: offsets, resets, timing
`ifndef MFRP_DEFS_SVH
`define MFRP_DEFS_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define MFRP_A_CTRL 4'h0
`define MFRP_A_SET_FREQ 4'h1
`define MFRP_A_ACC1 4'h2
`define MFRP_A_DEC1 4'h3
`define MFRP_A_ACC2 4'h4
`define MFRP_A_DEC2 4'h5
`define MFRP_A_SW_FREQ 4'h6
`define MFRP_A_START_FREQ 4'h7
`define MFRP_A_HOLD 4'h8
`define MFRP_A_BASE 4'h9
`define MFRP_A_MIN_FREQ 4'ha
`define MFRP_A_REF_FREQ 4'hb
`define MFRP_A_OUT 4'hc
`define MFRP_A_STAT 4'hd
`define MFRP_NUM_CFG 12
`define MFRP_NUM_CFG_A 4'hc

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define MFRP_CTRL_SHAPE 1:0
`define MFRP_CTRL_INCR 2

// ----------------------------------------------------------------
// Reset values and codes (frequency 0.1 Hz, time one increment)
// ----------------------------------------------------------------
`define MFRP_NOFUNC 16'h270f
`define MFRP_RST_CTRL 16'h0000
`define MFRP_RST_TIME 16'h0032
`define MFRP_RST_START 16'h0005
`define MFRP_RST_F60 16'h0258
`define MFRP_RST_ZERO 16'h0000
`define MFRP_START_MAX 16'h0258

// ----------------------------------------------------------------
// Timing, times in ms
// ----------------------------------------------------------------
`define MFRP_CLK_KHZ 20000
`define MFRP_FINE_MS 10
`define MFRP_COARSE_MS 100
`define MFRP_MIN_MS 40
`define MFRP_LIM_MS 30

// ----------------------------------------------------------------
// Curve A constants
// ----------------------------------------------------------------
`define MFRP_SA_NUM 64'h9
`define MFRP_SA_DEN 64'h8

`endif

// ---- mfrp_pkg.sv ----
// Types shared by the motor frequency ramp profiler
`default_nettype none
`include "mfrp_defs.svh"
package mfrp_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} mfrp_bus_t;

	typedef struct packed {
		logic [15:0] freq;
		logic reverse;
		logic running;
		logic second_set;
	} mfrp_cmd_t;

	typedef enum logic [2:0] {
		MFRP_ST_IDLE = 3'h1,
		MFRP_ST_HOLD = 3'h2,
		MFRP_ST_RUN = 3'h4
	} mfrp_state_t;

	typedef enum logic [1:0] {
		MFRP_SHAPE_LIN = 2'h0,
		MFRP_SHAPE_A = 2'h1,
		MFRP_SHAPE_B = 2'h2
	} mfrp_shape_t;

	// Reset value of each setting word
	function automatic logic [15:0] mfrp_rst_val(input logic [3:0] idx);
		logic [15:0] v;
		v = `MFRP_RST_ZERO;
		case (idx)
			`MFRP_A_CTRL: v = `MFRP_RST_CTRL;
			`MFRP_A_ACC1, `MFRP_A_DEC1, `MFRP_A_ACC2: v = `MFRP_RST_TIME;
			`MFRP_A_DEC2, `MFRP_A_SW_FREQ, `MFRP_A_HOLD: v = `MFRP_NOFUNC;
			`MFRP_A_START_FREQ: v = `MFRP_RST_START;
			`MFRP_A_BASE, `MFRP_A_REF_FREQ: v = `MFRP_RST_F60;
			default: v = `MFRP_RST_ZERO;
		endcase
		return v;
	endfunction : mfrp_rst_val
endpackage : mfrp_pkg

`default_nettype wire

// ---- mfrp_monitor.sv ----
// Port checker for the motor frequency ramp profiler
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Checker module
// ----------------------------------------------------------------
module mfrp_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire mfrp_pkg::mfrp_bus_t bus,
	input wire logic [15:0] rd_data_reg,
	input wire logic fwd_start_pin,
	input wire logic rev_start_pin,
	input wire logic second_set_select,
	input wire mfrp_pkg::mfrp_cmd_t motor_cmd_reg
);
	logic [15:0] set_q;
	logic [15:0] start_q;
	logic [15:0] sw_q;
	logic [15:0] min_q;

	// Shadow copies of the set, switch, start and minimum frequency settings, so launch values can be judged
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			set_q <= 16'h0000;
			start_q <= 16'h0005;
			sw_q <= 16'h270f;
			min_q <= 16'h0000;
		end
		else if (bus.wr && bus.addr == 4'h1)
			set_q <= bus.wdata;
		else if (bus.wr && bus.addr == 4'h7)
			start_q <= bus.wdata;
		else if (bus.wr && bus.addr == 4'h6)
			sw_q <= bus.wdata;
		else if (bus.wr && bus.addr == 4'ha)
			min_q <= bus.wdata;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_read_idle_zero: assert property (
		!$past(bus.rd) |-> rd_data_reg == 16'h0000) else $error("read data not idle");
	a_step_one_lsb: assert property (
		(motor_cmd_reg.running && $past(motor_cmd_reg.running) && $past(motor_cmd_reg.freq) != 16'h0000)
		|-> (motor_cmd_reg.freq <= $past(motor_cmd_reg.freq) + 16'h0001
		&& motor_cmd_reg.freq + 16'h0001 >= $past(motor_cmd_reg.freq)))
		else $error("frequency jumped");
	a_select_second: assert property (
		second_set_select [*5] |-> motor_cmd_reg.second_set) else $error("select ignored");
	a_launch_start: assert property (
		($rose(motor_cmd_reg.running) && start_q != 16'h0000) |-> motor_cmd_reg.freq == start_q)
		else $error("launch not at starting frequency");
	a_no_low_start: assert property (
		$rose(motor_cmd_reg.running) |-> (set_q >= start_q || start_q <= min_q))
		else $error("started below start");
	a_idle_zero: assert property (
		!motor_cmd_reg.running |-> motor_cmd_reg.freq == 16'h0000) else $error("idle output");
	a_auto_off: assert property (
		(sw_q == 16'h270f && !second_set_select) [*5] |-> !motor_cmd_reg.second_set)
		else $error("switched with switching off");
	a_zero_switch: assert property (
		(sw_q == 16'h0000 && motor_cmd_reg.running) |-> motor_cmd_reg.second_set)
		else $error("zero switch point not second");
endmodule : mfrp_monitor

bind mfrp_profiler mfrp_monitor u_mon (.clk(clk), .reset_n(reset_n), .bus(bus),
	.rd_data_reg(rd_data_reg), .fwd_start_pin(fwd_start_pin), .rev_start_pin(rev_start_pin),
	.second_set_select(second_set_select), .motor_cmd_reg(motor_cmd_reg));

`default_nettype wire

// ---- mfrp_term_model.sv ----
// Terminal contact model feeding the profiler's start and select pins
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Terminal model
// ----------------------------------------------------------------
module mfrp_term_model (
	input wire logic clk,
	input wire logic fwd_req,
	input wire logic rev_req,
	input wire logic sel_req,
	output logic fwd_start_pin,
	output logic rev_start_pin,
	output logic second_set_select
);
	// Contacts open at power up
	initial
	begin
		fwd_start_pin = 1'b0;
		rev_start_pin = 1'b0;
		second_set_select = 1'b0;
	end

	// Contacts change one tick after the request, never mid-cycle
	always @(posedge clk)
	begin
		fwd_start_pin <= fwd_req;
		rev_start_pin <= rev_req;
		second_set_select <= sel_req;
	end
endmodule : mfrp_term_model

`default_nettype wire

// ---- mfrp_profiler_tb.sv ----
// Self-checking testbench for the motor frequency ramp profiler
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module mfrp_profiler_tb;
	logic clk;
	logic reset_n;
	mfrp_pkg::mfrp_bus_t bus;
	logic [15:0] rd_data_reg;
	logic fwd_req;
	logic rev_req;
	logic sel_req;
	logic fwd_start_pin;
	logic rev_start_pin;
	logic second_set_select;
	mfrp_pkg::mfrp_cmd_t motor_cmd_reg;
	int fails;
	int cmp_count;
	int i;
	logic [15:0] dflt [15];
	logic [15:0] sw_tab [2];
	logic exp_tab [2];

	// Short counts keep ramps to a few hundred cycles
	mfrp_profiler #(.FINE_CYC(2), .COARSE_CYC(20), .MIN_CYC(8), .LIM_CYC(6)) dut (
		.clk(clk), .reset_n(reset_n), .bus(bus), .rd_data_reg(rd_data_reg),
		.fwd_start_pin(fwd_start_pin), .rev_start_pin(rev_start_pin),
		.second_set_select(second_set_select), .motor_cmd_reg(motor_cmd_reg));

	mfrp_term_model u_term (.clk(clk), .fwd_req(fwd_req), .rev_req(rev_req), .sel_req(sel_req),
		.fwd_start_pin(fwd_start_pin), .rev_start_pin(rev_start_pin),
		.second_set_select(second_set_select));

	// Free running 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic close_out;
		$display("compares %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk16

	task automatic chk1(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask : chk1

	// One idle cycle after each write, so a strobe is never set twice at one edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	// Read data is looked at mid-cycle, in the only cycle it stands
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		chk16("read", exp, rd_data_reg);
	endtask : rd_chk

	task automatic pins(input logic f, input logic r, input logic s);
		@(posedge clk);
		fwd_req <= f;
		rev_req <= r;
		sel_req <= s;
	endtask : pins

	// Bounded wait for a given output frequency and run flag
	task automatic wait_state(input logic [15:0] f, input logic r, input int bound);
		int n;
		n = 0;
		@(negedge clk);
		while ((motor_cmd_reg.freq !== f || motor_cmd_reg.running !== r) && n < bound)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= bound)
		begin
			fails++;
			$display("BAD wait expected %h seen %h", f, motor_cmd_reg.freq);
			close_out;
		end
	endtask : wait_state

	// Main sequence
	initial
	begin
		fails = 0;
		cmp_count = 0;
		bus = '0;
		fwd_req = 1'b0;
		rev_req = 1'b0;
		sel_req = 1'b0;
		reset_n = 1'b0;
		dflt = '{16'h0000, 16'h0000, 16'h0032, 16'h0032, 16'h0032, 16'h270f, 16'h270f,
			16'h0005, 16'h270f, 16'h0258, 16'h0000, 16'h0258, 16'h0000, 16'h0001, 16'h0000};
		sw_tab = '{16'h0000, 16'h00c8};
		exp_tab = '{1'b1, 1'b0};
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 15; i++)
			rd_chk(i[3:0], dflt[i]);
		wr(4'hc, 16'h1234);
		rd_chk(4'hc, 16'h0000);
		wr(4'h1, 16'h0003);
		pins(1'b1, 1'b0, 1'b0);
		repeat (20) @(negedge clk);
		chk1("running", 1'b0, motor_cmd_reg.running);
		pins(1'b0, 1'b0, 1'b0);
		// Let the dropped start pass the synchroniser before the command rises
		repeat (4) @(negedge clk);
		wr(4'h1, 16'h0064);
		rd_chk(4'h1, 16'h0064);
		pins(1'b1, 1'b0, 1'b0);
		wait_state(16'h0005, 1'b1, 20);
		wait_state(16'h0064, 1'b1, 400);
		chk1("second", 1'b0, motor_cmd_reg.second_set);
		rd_chk(4'hc, 16'h0064);
		rd_chk(4'hd, 16'h0004);
		pins(1'b1, 1'b0, 1'b1);
		repeat (6) @(negedge clk);
		chk1("second", 1'b1, motor_cmd_reg.second_set);
		pins(1'b0, 1'b0, 1'b0);
		wait_state(16'h0000, 1'b0, 400);
		wr(4'h4, 16'h0028);
		wr(4'h6, 16'h0032);
		pins(1'b1, 1'b0, 1'b0);
		wait_state(16'h0028, 1'b1, 200);
		chk1("second", 1'b0, motor_cmd_reg.second_set);
		wait_state(16'h0064, 1'b1, 200);
		chk1("second", 1'b1, motor_cmd_reg.second_set);
		pins(1'b0, 1'b0, 1'b0);
		wait_state(16'h0032, 1'b1, 78);
		wait_state(16'h0000, 1'b0, 300);
		for (i = 0; i < 2; i++)
		begin
			wr(4'h6, sw_tab[i]);
			pins(1'b1, 1'b0, 1'b0);
			wait_state(16'h0064, 1'b1, 400);
			chk1("second", exp_tab[i], motor_cmd_reg.second_set);
			pins(1'b0, 1'b0, 1'b0);
			wait_state(16'h0000, 1'b0, 400);
		end
		wr(4'h6, 16'h270f);
		for (i = 2; i >= 0; i--)
		begin
			wr(4'h0, i[15:0]);
			rd_chk(4'h0, i[15:0]);
			pins(1'b1, 1'b0, 1'b0);
			wait_state(16'h0064, 1'b1, 2000);
			pins(1'b0, 1'b0, 1'b0);
			wait_state(16'h0000, 1'b0, 2000);
		end
		wr(4'h8, 16'h000a);
		pins(1'b1, 1'b0, 1'b0);
		wait_state(16'h0005, 1'b1, 20);
		repeat (20) @(negedge clk);
		chk16("freq", 16'h0005, motor_cmd_reg.freq);
		rd_chk(4'hd, 16'h0002);
		pins(1'b0, 1'b0, 1'b0);
		wait_state(16'h0000, 1'b0, 40);
		pins(1'b1, 1'b0, 1'b0);
		wait_state(16'h0064, 1'b1, 500);
		pins(1'b0, 1'b1, 1'b0);
		// Reversal passes through zero while still running
		wait_state(16'h0000, 1'b1, 400);
		wait_state(16'h0064, 1'b1, 400);
		chk1("reverse", 1'b1, motor_cmd_reg.reverse);
		pins(1'b0, 1'b0, 1'b0);
		wait_state(16'h0000, 1'b0, 400);
		// Fine increments: coarse steps would take ten times as long
		wr(4'h8, 16'h270f);
		wr(4'h0, 16'h0004);
		wr(4'h2, 16'h0320);
		pins(1'b1, 1'b0, 1'b0);
		wait_state(16'h0064, 1'b1, 400);
		pins(1'b0, 1'b0, 1'b0);
		wait_state(16'h0000, 1'b0, 400);
		// Minimum frequency acts as command when none is set
		wr(4'h1, 16'h0000);
		wr(4'ha, 16'h000a);
		pins(1'b1, 1'b0, 1'b0);
		wait_state(16'h000a, 1'b1, 100);
		chk1("running", 1'b1, motor_cmd_reg.running);
		pins(1'b0, 1'b0, 1'b0);
		wait_state(16'h0000, 1'b0, 100);
		close_out;
	end
endmodule : mfrp_profiler_tb

`default_nettype wire
